// file: core/ssi_pkg.sv
// Constants and carrier types for the serial status and interrupt logic.
// Assumes a single 100 MHz clock domain shared with the shifter logic.
package ssi_pkg;

  // ------------------------------------------------------------
  // Register map (byte-wide registers, 3-bit address)
  // ------------------------------------------------------------
  localparam int          ADDR_W       = 3;
  localparam int          DATA_W       = 8;
  localparam logic [2:0]  ADDR_STATUS  = 3'h0;
  localparam logic [2:0]  ADDR_DATA    = 3'h1;
  localparam logic [2:0]  ADDR_IRQ_EN  = 3'h2;
  localparam logic [2:0]  ADDR_CLEAR   = 3'h3;
  localparam logic [2:0]  ADDR_MODE    = 3'h4;

  // ------------------------------------------------------------
  // Status field positions and reset values
  // ------------------------------------------------------------
  localparam int          BIT_TX_EMPTY = 7;
  localparam int          BIT_TX_DONE  = 6;
  localparam int          BIT_RX_FULL  = 5;
  localparam int          BIT_IDLE     = 4;
  localparam int          BIT_OVERRUN  = 3;
  localparam int          BIT_NOISE    = 2;
  localparam int          BIT_FRAMING  = 1;
  localparam int          BIT_PARITY   = 0;
  localparam int          BIT_MUTE     = 0;
  localparam logic [7:0]  STATUS_RST   = 8'hC0;
  localparam logic [7:0]  ZERO8        = 8'h00;
  // Flags cleared by the status-then-data-write sequence
  localparam logic [7:0]  CLR_ON_WRITE = 8'hC1;
  // Flags cleared by the status-then-data-read sequence
  localparam logic [7:0]  CLR_ON_READ  = 8'h3F;
  // Flags tied to reception, silenced while muted
  localparam logic [7:0]  RX_FLAGS     = 8'h3F;

  // ------------------------------------------------------------
  // Carriers from the shifter logic
  // ------------------------------------------------------------
  typedef struct packed {
    logic       load;        // Buffer moved into the shift register
    logic       frame_done;  // Frame finished on the line
    logic       special;     // That frame was a preamble or break
  } ssi_tx_evt_t;

  typedef struct packed {
    logic       word_ready;  // Shifted-in word ready for the buffer
    logic       noise;
    logic       framing;
    logic       parity_fail;
    logic       idle;        // Idle line detected
    logic       wake;        // Wake-up event ends mute
    logic [7:0] data;
  } ssi_rx_evt_t;

endpackage : ssi_pkg

// file: core/ssi_core.sv
// Status flags, clearing sequences, shared interrupt request and
// low-power behaviour of an asynchronous serial interface.
// Assumes the shifter logic runs on clk and delivers one-cycle event
// pulses; the register port master never overlaps strobes.
// Reads stay live in halt so software can inspect the frozen state.
//
// Overview of operation
// - Wait mode: run normally, interrupt wakes CPU
// - Halt mode: freeze registers, stop line activity
// - All sources merge onto one request line
// - Request needs flag, enable, clear global mask
// - Status resets to C0h, all read-only
// - Tx empty sets on buffer-to-shifter move
// - Status access then data write clears tx flags
// - Tx complete sets after data frames only
// - Rx full sets on buffer load
// - Status access then data read clears rx flags
// - Idle sets once per received word
// - Overrun sets on new word while full
// - Overrun keeps buffer, shifter overwritten
// - Noise flag raises no own interrupt
// - Framing flag raises no own interrupt
// - Framing plus overrun sets overrun only
// - Parity flag clears on status then data
// - Mute blocks rx flags and rx interrupts
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module ssi_core (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // Register port
  input  wire logic [ssi_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [ssi_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output var  logic [ssi_pkg::DATA_W-1:0] reg_rdata,
  // Shifter events
  input  wire ssi_pkg::ssi_tx_evt_t       tx_evt,
  input  wire ssi_pkg::ssi_rx_evt_t       rx_evt,
  // Processor state
  input  wire logic                       cpu_irq_mask,
  input  wire logic                       wait_mode,
  input  wire logic                       halt_mode,
  // To the shifter logic
  output var  logic [7:0]                 tx_data,
  output var  logic                       tx_data_valid,
  output var  logic                       serial_run,
  output var  logic                       rx_mute,
  // To the interrupt controller
  output var  logic                       irq,
  output var  logic                       wait_wake
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Spreads the five enable bits onto the status layout; overrun
  // shares the receiver enable, noise and framing never request.
  function automatic logic [7:0] en_map(input logic [7:0] en);
    logic [7:0] m;
    m = ssi_pkg::ZERO8;
    m[ssi_pkg::BIT_TX_EMPTY] = en[ssi_pkg::BIT_TX_EMPTY];
    m[ssi_pkg::BIT_TX_DONE]  = en[ssi_pkg::BIT_TX_DONE];
    m[ssi_pkg::BIT_RX_FULL]  = en[ssi_pkg::BIT_RX_FULL];
    m[ssi_pkg::BIT_IDLE]     = en[ssi_pkg::BIT_IDLE];
    m[ssi_pkg::BIT_OVERRUN]  = en[ssi_pkg::BIT_RX_FULL];
    m[ssi_pkg::BIT_PARITY]   = en[ssi_pkg::BIT_PARITY];
    return m;
  endfunction

  function automatic logic hit(input logic [2:0] a, input logic [2:0] b);
    return a == b;
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [7:0] seen_q;       // Flags captured at the status access
  logic       armed_q;      // Status accessed, awaiting data access
  logic [7:0] irq_en_q;
  logic       mute_q;
  logic       idle_arm_q;   // Idle may set again
  logic [7:0] rx_buf_q;
  logic [7:0] tx_buf_q;
  logic       tx_valid_q;
  logic [7:0] rdata_q;
  logic       irq_q;
  logic       wake_q;
  logic       run_q;

  logic       run;
  logic       st_acc;
  logic       dat_wr;
  logic       dat_rd;
  logic       clr_wr;
  logic       en_wr;
  logic       mode_wr;
  logic [7:0] set_tx;
  logic [7:0] set_rx;
  logic [7:0] set_v;
  logic [7:0] clr_v;
  logic       rx_ok;
  logic       ovr;
  logic [7:0] en_v;
  logic       req_tx_empty;
  logic       req_tx_done;
  logic       req_rx_full;
  logic       req_overrun;
  logic       req_idle;
  logic       req_parity;
  logic       req_tx;
  logic       req_rx;
  logic       req_any;
  logic       irq_cond;

  // ------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------
  // Status, buffers and control hold in halt, reads stay live; the shifter is told to stop as well
  assign run    = ~halt_mode;
  assign st_acc = run & (reg_rd | reg_wr) & hit(reg_addr, ssi_pkg::ADDR_STATUS);
  assign dat_wr = run & reg_wr & hit(reg_addr, ssi_pkg::ADDR_DATA);
  assign dat_rd = run & reg_rd & hit(reg_addr, ssi_pkg::ADDR_DATA);
  assign clr_wr = run & reg_wr & hit(reg_addr, ssi_pkg::ADDR_CLEAR);
  assign en_wr  = run & reg_wr & hit(reg_addr, ssi_pkg::ADDR_IRQ_EN);
  assign mode_wr = run & reg_wr & hit(reg_addr, ssi_pkg::ADDR_MODE);
  assign rx_ok  = run & ~mute_q;
  assign ovr    = rx_evt.word_ready & status_q[ssi_pkg::BIT_RX_FULL];

  // ------------------------------------------------------------
  // Transmit flag set terms
  // ------------------------------------------------------------
  always_comb begin
    set_tx = ssi_pkg::ZERO8;
    if (run) begin
      set_tx[ssi_pkg::BIT_TX_EMPTY] = tx_evt.load;
      // Preamble and break frames do not report completion
      set_tx[ssi_pkg::BIT_TX_DONE]  = tx_evt.frame_done
                                      & ~tx_evt.special;
    end
  end

  // ------------------------------------------------------------
  // Receive flag set terms
  // ------------------------------------------------------------
  // An overrun word reports only the overrun, so a framing error
  // on that word stays hidden as well
  always_comb begin
    set_rx = ssi_pkg::ZERO8;
    if (rx_ok) begin
      set_rx[ssi_pkg::BIT_OVERRUN] = ovr;
      set_rx[ssi_pkg::BIT_RX_FULL] = rx_evt.word_ready & ~ovr;
      set_rx[ssi_pkg::BIT_NOISE]   = rx_evt.word_ready & ~ovr
                                     & rx_evt.noise;
      set_rx[ssi_pkg::BIT_FRAMING] = rx_evt.word_ready & ~ovr
                                     & rx_evt.framing;
      set_rx[ssi_pkg::BIT_PARITY]  = rx_evt.word_ready & ~ovr
                                     & rx_evt.parity_fail;
      set_rx[ssi_pkg::BIT_IDLE]    = rx_evt.idle & idle_arm_q;
    end
  end

  // ------------------------------------------------------------
  // Clear terms
  // ------------------------------------------------------------
  // Only flags captured at the status access may be cleared, so an
  // event landing between the two accesses stays visible
  always_comb begin
    clr_v = ssi_pkg::ZERO8;
    if (armed_q && dat_wr) begin
      clr_v = seen_q & ssi_pkg::CLR_ON_WRITE;
    end
    if (armed_q && dat_rd) begin
      clr_v = seen_q & ssi_pkg::CLR_ON_READ;
    end
    // The clear register adds write-one bits of its own
    if (clr_wr) begin
      clr_v = clr_v | reg_wdata;
    end
  end

  // A set in the same cycle beats the clear
  assign set_v    = set_tx | set_rx;
  assign status_d = (status_q & ~clr_v) | set_v;

  // ------------------------------------------------------------
  // Status register
  // ------------------------------------------------------------
  // Read-only to software: only event and clear terms move it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_q <= ssi_pkg::STATUS_RST;
    end else begin
      status_q <= status_d;
    end
  end

  // ------------------------------------------------------------
  // Clearing sequence tracker
  // ------------------------------------------------------------
  // Any data access ends the sequence, whether or not it cleared;
  // a status write arms it just as a read does
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
      seen_q  <= ssi_pkg::ZERO8;
    end else if (st_acc) begin
      armed_q <= 1'b1;
      seen_q  <= status_q;
    end else if (dat_wr || dat_rd) begin
      armed_q <= 1'b0;
      seen_q  <= ssi_pkg::ZERO8;
    end
  end

  // ------------------------------------------------------------
  // Idle re-arm: one idle report per received word
  // ------------------------------------------------------------
  // Armed at reset so the first idle line after start-up reports
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idle_arm_q <= 1'b1;
    end else if (set_v[ssi_pkg::BIT_RX_FULL]) begin
      idle_arm_q <= 1'b1;
    end else if (set_v[ssi_pkg::BIT_IDLE]) begin
      idle_arm_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Receive buffer
  // ------------------------------------------------------------
  // On overrun the held word stays; the shifter keeps the new one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_buf_q <= ssi_pkg::ZERO8;
    end else if (rx_ok && rx_evt.word_ready && !ovr) begin
      rx_buf_q <= rx_evt.data;
    end
  end

  // ------------------------------------------------------------
  // Transmit buffer
  // ------------------------------------------------------------
  // A data write landing with a load keeps the buffer valid, so the
  // new word is not lost to the move of the old one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_buf_q   <= ssi_pkg::ZERO8;
      tx_valid_q <= 1'b0;
    end else if (dat_wr) begin
      tx_buf_q   <= reg_wdata;
      tx_valid_q <= 1'b1;
    end else if (run && tx_evt.load) begin
      tx_valid_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_en_q <= ssi_pkg::ZERO8;
    end else if (en_wr) begin
      irq_en_q <= reg_wdata;
    end
  end

  // Software write beats a wake event in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mute_q <= 1'b0;
    end else if (mode_wr) begin
      mute_q <= reg_wdata[ssi_pkg::BIT_MUTE];
    end else if (run && rx_evt.wake) begin
      mute_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= ssi_pkg::ZERO8;
    end else if (reg_rd) begin
      case (reg_addr)
        ssi_pkg::ADDR_STATUS: rdata_q <= status_q;
        ssi_pkg::ADDR_DATA:   rdata_q <= rx_buf_q;
        ssi_pkg::ADDR_IRQ_EN: rdata_q <= irq_en_q;
        ssi_pkg::ADDR_MODE:   rdata_q <= {7'h00, mute_q};
        default:              rdata_q <= ssi_pkg::ZERO8;
      endcase
    end else begin
      rdata_q <= ssi_pkg::ZERO8;
    end
  end

  // ------------------------------------------------------------
  // Shared interrupt request and wait wake-up
  // ------------------------------------------------------------
  // Noise and framing carry no enable: they ride on rx full
  assign en_v = en_map(irq_en_q);

  assign req_tx_empty = status_q[ssi_pkg::BIT_TX_EMPTY]
                        & en_v[ssi_pkg::BIT_TX_EMPTY];
  assign req_tx_done  = status_q[ssi_pkg::BIT_TX_DONE]
                        & en_v[ssi_pkg::BIT_TX_DONE];
  assign req_rx_full  = status_q[ssi_pkg::BIT_RX_FULL]
                        & en_v[ssi_pkg::BIT_RX_FULL];
  assign req_overrun  = status_q[ssi_pkg::BIT_OVERRUN]
                        & en_v[ssi_pkg::BIT_OVERRUN];
  assign req_idle     = status_q[ssi_pkg::BIT_IDLE]
                        & en_v[ssi_pkg::BIT_IDLE];
  assign req_parity   = status_q[ssi_pkg::BIT_PARITY]
                        & en_v[ssi_pkg::BIT_PARITY];

  // Transmit requests are untouched by mute
  assign req_tx  = req_tx_empty | req_tx_done;
  // Receive requests are dropped while muted
  assign req_rx  = ~mute_q & (req_rx_full | req_overrun
                              | req_idle | req_parity);
  assign req_any = req_tx | req_rx;
  assign irq_cond = req_any & ~cpu_irq_mask;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_q  <= 1'b0;
      wake_q <= 1'b0;
      run_q  <= 1'b0;
    end else begin
      irq_q  <= irq_cond;
      // Halt cannot be left through a serial event
      wake_q <= irq_cond & wait_mode & run;
      run_q  <= run;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Each output is a plain copy of a register, no logic after it
  assign reg_rdata     = rdata_q;
  assign tx_data       = tx_buf_q;
  assign tx_data_valid = tx_valid_q;
  assign serial_run    = run_q;
  assign rx_mute       = mute_q;
  assign irq           = irq_q;
  assign wait_wake     = wake_q;

endmodule // ssi_core

`default_nettype wire

// file: tb/ssi_core_props.sv
// Port checker for ssi_core.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ssi_core_props (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       rst_n,
  // Register port
  input wire logic [ssi_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ssi_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                       reg_wr,
  // Events and processor state
  input wire ssi_pkg::ssi_tx_evt_t       tx_evt,
  input wire ssi_pkg::ssi_rx_evt_t       rx_evt,
  input wire logic                       cpu_irq_mask,
  input wire logic                       wait_mode,
  input wire logic                       halt_mode,
  // Outputs under watch
  input wire logic [7:0]                 tx_data,
  input wire logic                       tx_data_valid,
  input wire logic                       serial_run,
  input wire logic                       rx_mute,
  input wire logic                       irq,
  input wire logic                       wait_wake
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic data_wr;
  logic mode_wr;
  logic tx_load;
  logic wake_ev;
  // Mode write beats wake in the same cycle
  assign data_wr = reg_wr && !halt_mode && !tx_evt.load
                   && reg_addr == ssi_pkg::ADDR_DATA;
  assign mode_wr = reg_wr && !halt_mode && reg_addr == ssi_pkg::ADDR_MODE;
  assign tx_load = tx_evt.load && !halt_mode && !reg_wr;
  assign wake_ev = rx_evt.wake && !halt_mode && !mode_wr;
  AST_WAIT_WAKE: assert property ($past(rst_n) |->
    wait_wake == (irq && $past(wait_mode) && !$past(halt_mode)))
    else $error("wake level wrong");
  AST_HALT_RUN: assert property ($past(rst_n) |->
    serial_run == !$past(halt_mode)) else $error("run level wrong");
  AST_HALT_FREEZE: assert property ($past(rst_n) && $past(halt_mode) |->
    $stable(tx_data) && $stable(tx_data_valid) && $stable(rx_mute))
    else $error("state moved in halt");
  AST_IRQ_MASK: assert property ($past(rst_n) && $past(cpu_irq_mask)
    |-> !irq) else $error("irq while masked");
  AST_TX_LOAD: assert property ($past(rst_n) && $past(tx_load)
    |-> !tx_data_valid) else $error("buffer still valid");
  AST_TX_WRITE: assert property ($past(rst_n) && $past(data_wr) |->
    tx_data_valid && tx_data == $past(reg_wdata))
    else $error("data write lost");
  AST_MUTE_SET: assert property ($past(rst_n) && $past(mode_wr) |->
    rx_mute == $past(reg_wdata[0])) else $error("mute not written");
  AST_MUTE_WAKE: assert property ($past(rst_n) && $past(wake_ev)
    |-> !rx_mute) else $error("wake kept mute");
  cover property (irq && !cpu_irq_mask);
  cover property (wait_wake);
  cover property (halt_mode && reg_wr);
endmodule // ssi_core_props
bind ssi_core ssi_core_props i_props (.clk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .tx_evt, .rx_evt, .cpu_irq_mask, .wait_mode, .halt_mode,
  .tx_data, .tx_data_valid, .serial_run, .rx_mute, .irq, .wait_wake);
`default_nettype wire

// file: tb/ssi_line_model.sv
// Shifter and line side model: issues one-cycle event pulses.
// Assumes the caller is on the clk domain of the core.
`timescale 1ns/1ps
`default_nettype none
module ssi_line_model (
  // Clock
  input  wire logic                 clk,
  // Events towards the core
  output var  ssi_pkg::ssi_tx_evt_t tx_evt,
  output var  ssi_pkg::ssi_rx_evt_t rx_evt
);
  initial begin
    tx_evt = '0;
    rx_evt = '0;
  end
  task automatic tx(input logic l, d, s);
    @(posedge clk);
    tx_evt <= '{load: l, frame_done: d, special: s};
    @(posedge clk);
    tx_evt <= '0;
  endtask
  task automatic word(input logic [7:0] v, input logic n, f, p);
    @(posedge clk);
    rx_evt <= '{1'b1, n, f, p, 1'b0, 1'b0, v};
    @(posedge clk);
    // Levels are void after the pulse, so show junk
    rx_evt <= '{1'b0, ~n, ~f, ~p, 1'b0, 1'b0, ~v};
  endtask
  task automatic pulse(input logic i, w);
    @(posedge clk);
    rx_evt.idle <= i;
    rx_evt.wake <= w;
    @(posedge clk);
    rx_evt.idle <= 1'b0;
    rx_evt.wake <= 1'b0;
  endtask
endmodule // ssi_line_model
`default_nettype wire

// file: tb/tb_serial_status_interrupt_logic.sv
// Self-checking bench for ssi_core with a line side model.
// Assumes a 100 MHz clock and register reads answered one cycle late.
`timescale 1ns/1ps
`default_nettype none
module tb_serial_status_interrupt_logic;
  localparam logic [2:0] ST = ssi_pkg::ADDR_STATUS;
  localparam logic [2:0] DT = ssi_pkg::ADDR_DATA;
  localparam logic [2:0] EN = ssi_pkg::ADDR_IRQ_EN;
  localparam logic [2:0] CL = ssi_pkg::ADDR_CLEAR;
  localparam logic [2:0] MD = ssi_pkg::ADDR_MODE;
  logic clk, rst_n, reg_wr, reg_rd, cpu_irq_mask, wait_mode, halt_mode;
  logic tx_data_valid, serial_run, rx_mute, irq, wait_wake;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, tx_data;
  ssi_pkg::ssi_tx_evt_t tx_evt;
  ssi_pkg::ssi_rx_evt_t rx_evt;
  int mismatches, total_checks;
  ssi_core i_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .tx_evt, .rx_evt, .cpu_irq_mask, .wait_mode, .halt_mode,
    .tx_data, .tx_data_valid, .serial_run, .rx_mute, .irq, .wait_wake);
  ssi_line_model i_line (.clk, .tx_evt, .rx_evt);
  task automatic chk(input string nm, input logic [7:0] e, g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk($sformatf("reg %0d", a), e, reg_rdata);
  endtask
  task automatic ck_irq(input logic [7:0] e);
    chk("irq", e, {7'h00, irq});
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {rst_n, reg_wr, reg_rd, cpu_irq_mask, wait_mode, halt_mode} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(ST, 8'hC0);
    wr(ST, 8'hFF);
    rd(ST, 8'hC0);
    rd(3'h7, 8'h00);
    wr(EN, 8'h80);
    rd(EN, 8'h80);
    ck_irq(8'h01);
    @(posedge clk) cpu_irq_mask <= 1'b1;
    repeat (2) @(posedge clk);
    #1 ck_irq(8'h00);
    @(posedge clk) cpu_irq_mask <= 1'b0;
    rd(ST, 8'hC0);
    wr(DT, 8'hA5);
    rd(ST, 8'h00);
    chk("tx_data", 8'hA5, tx_data);
    i_line.tx(1'b1, 1'b0, 1'b0);
    rd(ST, 8'h80);
    chk("tx_valid", 8'h00, {7'h00, tx_data_valid});
    wr(EN, 8'h40);
    i_line.tx(1'b0, 1'b1, 1'b1);
    rd(ST, 8'h80);
    ck_irq(8'h00);
    i_line.tx(1'b0, 1'b1, 1'b0);
    rd(ST, 8'hC0);
    ck_irq(8'h01);
    $display("test tx done");
    wr(EN, 8'h20);
    i_line.word(8'h55, 1'b0, 1'b0, 1'b0);
    rd(ST, 8'hE0);
    ck_irq(8'h01);
    i_line.word(8'h66, 1'b0, 1'b1, 1'b0);
    rd(ST, 8'hE8);
    rd(DT, 8'h55);
    rd(ST, 8'hC0);
    ck_irq(8'h00);
    wr(EN, 8'h0E);
    i_line.word(8'h11, 1'b1, 1'b0, 1'b0);
    rd(ST, 8'hE4);
    ck_irq(8'h00);
    rd(DT, 8'h11);
    wr(EN, 8'h01);
    i_line.word(8'h22, 1'b0, 1'b0, 1'b1);
    rd(ST, 8'hE1);
    ck_irq(8'h01);
    wr(DT, 8'h33);
    rd(ST, 8'h20);
    rd(DT, 8'h22);
    rd(ST, 8'h00);
    $display("test rx done");
    wr(EN, 8'h10);
    i_line.pulse(1'b1, 1'b0);
    rd(ST, 8'h10);
    ck_irq(8'h01);
    wr(CL, 8'h10);
    rd(ST, 8'h00);
    ck_irq(8'h00);
    i_line.pulse(1'b1, 1'b0);
    rd(ST, 8'h00);
    i_line.word(8'h44, 1'b0, 1'b0, 1'b0);
    rd(DT, 8'h44);
    rd(ST, 8'h20);
    i_line.pulse(1'b1, 1'b0);
    rd(ST, 8'h30);
    rd(DT, 8'h44);
    rd(ST, 8'h00);
    wr(MD, 8'h01);
    rd(MD, 8'h01);
    i_line.word(8'h77, 1'b1, 1'b1, 1'b1);
    i_line.pulse(1'b1, 1'b0);
    rd(ST, 8'h00);
    i_line.pulse(1'b0, 1'b1);
    rd(MD, 8'h00);
    $display("test idle and mute done");
    wr(EN, 8'h20);
    i_line.word(8'h88, 1'b0, 1'b0, 1'b0);
    rd(ST, 8'h20);
    @(posedge clk) wait_mode <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("wake", 8'h01, {7'h00, wait_wake});
    @(posedge clk) wait_mode <= 1'b0;
    @(posedge clk) halt_mode <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("run", 8'h00, {7'h00, serial_run});
    i_line.word(8'h99, 1'b0, 1'b0, 1'b0);
    wr(DT, 8'h5A);
    wr(EN, 8'h00);
    rd(ST, 8'h20);
    @(posedge clk) halt_mode <= 1'b0;
    rd(EN, 8'h20);
    rd(DT, 8'h88);
    chk("tx_data", 8'h33, tx_data);
    $display("test low power done");
    results();
  end
  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    results();
  end
endmodule // tb_serial_status_interrupt_logic
`default_nettype wire
